// ### core/usffc_top.sv
// Flags, interrupt requests and line format control of the serial module
// Functional notes
// - Character into buffer sets receive-full; irq only with its enable
// - Ten or eleven idle ones set idle flag; irq with idle enable
// - Character before previous read sets overrun; old character kept
// - Overrun raises error irq only with overrun enable
// - Noise in any bit sets noise flag; error irq with enable
// - Zero at stop bit sets framing flag; error irq with enable
// - Parity mismatch sets parity flag; error irq with enable
// - Wait mode: module runs, registers blocked, enabled irq wakes
// - Stop mode halts module, registers kept; resumes afterwards
// - Break with permit clear: accesses leave flags untouched
// - Break with permit set: flags clear and stay cleared
// - Enabled module drives transmit pin as output
// - Enabled module treats receive pin as input
// - Loopback feeds transmitter to receiver; reset clears it
// - Enable bit runs module; clearing sets empty and done flags
// - Invert bit inverts every transmitted level
// - Length bit picks nine-bit or eight-bit characters
// - Wake select picks address mark or idle line; reset clears
// - Idle count starts after stop bit when set, else start bit
// - Parity enable generates and checks parity in top bit
// - Odd parity when set, even when clear
// - One start, one stop; ten or eleven bits per frame
// - Wake select set: address mark clears standby bit
`include "usffc_cfg.svh"
module usffc_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Receiver and transmitter core side
  input wire usffc_pkg::usffc_rxchar_type rx_char_in,
  input wire logic rx_idle_bit_in,
  input wire logic tx_serial_in,
  input wire logic tx_load_in,
  input wire logic tx_busy_in,
  output logic rx_serial_out,
  output logic [1:0] char_bits_out,
  output logic odd_parity_out,
  output logic parity_enable_out,
  output logic baud_enable_out,
  // System state
  input wire logic wait_mode_in,
  input wire logic stop_mode_in,
  input wire logic break_state_in,
  input wire logic break_clear_permit_in,
  input wire logic tx_pin_direction_in,
  input wire logic rx_pin_direction_in,
  // Pins
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  output logic serial_in_pin_oe_out,
  // Interrupt requests
  output logic rx_irq_out,
  output logic err_irq_out,
  output logic tx_irq_out,
  output logic wake_request_out
);
  import usffc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] line_format_control_q;
  logic [7:0] control_reg_two_q;
  logic [7:0] control_reg_three_q;
  logic [7:0] status_reg_one_q;
  logic [7:0] data_buffer_q;
  logic bit8_q;
  logic st1_seen_q;
  logic [3:0] idle_cnt_q;
  logic idle_armed_q;
  logic [1:0] pin_sync_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  usffc_rd_state_type rd_state_q;
  logic wake_event;

  function automatic logic par_of(input logic [8:0] d, input logic len9);
    par_of = len9 ? ^d[7:0] : ^d[6:0];
  endfunction : par_of

  ////////////////////////////////////////////////////////////////////////
  // Format decode
  wire en = line_format_control_q[`USFFC_LFC_EN];
  wire len9 = line_format_control_q[`USFFC_LFC_LEN9];
  wire parity_enable = line_format_control_q[`USFFC_LFC_PEN];
  wire odd = line_format_control_q[`USFFC_LFC_ODD];
  wire loop = line_format_control_q[`USFFC_LFC_LOOP];
  wire wake_addr = line_format_control_q[`USFFC_LFC_WAKE];
  wire active = en && !stop_mode_in;
  wire standby = control_reg_two_q[`USFFC_CR2_STBY];
  assign char_bits_out = len9 ? 2'd1 : 2'd0;
  assign odd_parity_out = odd;
  assign parity_enable_out = parity_enable;
  assign baud_enable_out = active;

  ////////////////////////////////////////////////////////////////////////
  // Pins
  wire tx_lvl = tx_serial_in ^ line_format_control_q[`USFFC_LFC_TX_POLARITY_INVERT];
  assign serial_out_pin_out = en ? tx_lvl : 1'b1;
  assign serial_out_pin_oe_out = en | tx_pin_direction_in;
  assign serial_in_pin_oe_out = en ? 1'b0 : rx_pin_direction_in;
  wire loop_ok = loop && control_reg_two_q[`USFFC_CR2_TE]
                 && control_reg_two_q[`USFFC_CR2_RE];
  assign rx_serial_out = loop_ok ? tx_serial_in : pin_sync_q[1];

  always_ff @(posedge clock_in) begin
    if (srst_in)
      pin_sync_q <= 2'b11;
    else
      pin_sync_q <= {pin_sync_q[0], serial_in_pin_in};
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: write taken when both halves are held or presented, read in two states
  wire wr_go = (aw_hold_q || s_axi_awvalid_in) && (w_hold_q || s_axi_wvalid_in)
               && !s_axi_bvalid_out;
  wire [7:0] wa = aw_hold_q ? aw_addr_q : s_axi_awaddr_in;
  wire [31:0] wd = w_hold_q ? w_data_q : s_axi_wdata_in;
  wire [3:0] ws = w_hold_q ? w_strb_q : s_axi_wstrb_in;
  wire bus_ok = !wait_mode_in;
  wire wr_b0 = wr_go && ws[0] && bus_ok;
  wire rd_go = s_axi_arvalid_in && rd_state_q == USFFC_RD_IDLE;
  wire rd_ok = rd_go && bus_ok;
  wire may_clear = !break_state_in || break_clear_permit_in;
  wire wr_lfc = wr_b0 && wa == `USFFC_OFF_LFC;
  wire wr_cr2 = wr_b0 && wa == `USFFC_OFF_CR2 && en;
  wire wr_cr3 = wr_b0 && wa == `USFFC_OFF_CR3;
  wire wr_data = wr_b0 && wa == `USFFC_OFF_DATA;
  wire rd_st1 = rd_ok && s_axi_araddr_in == `USFFC_OFF_ST1;
  wire rd_data = rd_ok && s_axi_araddr_in == `USFFC_OFF_DATA;
  wire wr_known = wa <= `USFFC_OFF_SYS && wa[1:0] == 2'b00;
  wire rd_known = s_axi_araddr_in <= `USFFC_OFF_SYS
                  && s_axi_araddr_in[1:0] == 2'b00;
  // Two-step clear: status read arms, data access completes
  wire clr_rx = rd_data && st1_seen_q && may_clear;
  wire clr_tx = wr_data && st1_seen_q && may_clear;

  assign s_axi_awready_out = !aw_hold_q && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_hold_q && !s_axi_bvalid_out;
  assign s_axi_arready_out = rd_state_q == USFFC_RD_IDLE;
  assign s_axi_rvalid_out = rd_state_q == USFFC_RD_RESP;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (wr_known && bus_ok) ? 2'b00 : 2'b10;
      end else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  wire [7:0] rd_mux =
    s_axi_araddr_in == `USFFC_OFF_LFC ? line_format_control_q :
    s_axi_araddr_in == `USFFC_OFF_CR2 ? control_reg_two_q :
    s_axi_araddr_in == `USFFC_OFF_CR3 ? {bit8_q, control_reg_three_q[6:0]} :
    s_axi_araddr_in == `USFFC_OFF_ST1 ? status_reg_one_q :
    s_axi_araddr_in == `USFFC_OFF_DATA ? data_buffer_q :
    s_axi_araddr_in == `USFFC_OFF_SYS ?
      {4'h0, stop_mode_in, wait_mode_in, break_state_in,
       break_clear_permit_in} : 8'h00;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_state_q <= USFFC_RD_IDLE;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= 2'b00;
    end else if (rd_go) begin
      rd_state_q <= USFFC_RD_RESP;
      // Registers stay hidden from the bus in wait mode
      s_axi_rdata_out <= bus_ok ? {24'h0, rd_mux} : 32'h0;
      s_axi_rresp_out <= (rd_known && bus_ok) ? 2'b00 : 2'b10;
    end else if (s_axi_rready_in)
      rd_state_q <= USFFC_RD_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers, all cleared by reset
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      line_format_control_q <= 8'h00;
      control_reg_two_q <= 8'h00;
      control_reg_three_q <= 8'h00;
    end else begin
      if (wr_lfc)
        line_format_control_q <= wd[7:0];
      if (wr_cr2)
        control_reg_two_q <= wd[7:0];
      else if (standby && wake_event)
        control_reg_two_q[`USFFC_CR2_STBY] <= 1'b0;
      if (wr_cr3)
        control_reg_three_q <= {1'b0, wd[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive character and idle detection
  wire rx_take = rx_char_in.valid && active
                 && control_reg_two_q[`USFFC_CR2_RE];
  wire addr_mark = len9 ? rx_char_in.data[8] : rx_char_in.data[7];
  wire char_ok = !standby || (wake_addr && addr_mark);
  wire rx_new = rx_take && char_ok;
  wire rx_full = status_reg_one_q[`USFFC_ST_RXF];
  wire ovr = rx_new && rx_full;
  wire par_bad = parity_enable && (par_of(rx_char_in.data, len9)
                 ^ (len9 ? rx_char_in.data[8] : rx_char_in.data[7])
                 ^ odd) == 1'b1;
  wire [3:0] idle_need = len9 ? `USFFC_IDLE_LONG : `USFFC_IDLE_SHORT;
  wire idle_hit = idle_armed_q && active && rx_idle_bit_in
                  && idle_cnt_q == idle_need - 4'd1;
  assign wake_event = (wake_addr && rx_take && addr_mark)
                      || (!wake_addr && idle_hit);
  wire idle_set = idle_hit && !(standby && !wake_addr);

  // Counting restarts on a frame; IDLE_COUNT_START_SELECT chooses whether frame bits count
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      idle_cnt_q <= 4'd0;
      idle_armed_q <= 1'b0;
    end else if (!active)
      idle_cnt_q <= 4'd0;
    else if (rx_char_in.valid) begin
      idle_cnt_q <= line_format_control_q[`USFFC_LFC_IDLE_COUNT_START_SELECT] ? 4'd0
                    : (rx_char_in.data[7] ? 4'd1 : 4'd0);
      idle_armed_q <= 1'b1;
    end else if (rx_idle_bit_in) begin
      if (idle_hit) begin
        idle_cnt_q <= 4'd0;
        idle_armed_q <= 1'b0;
      end else if (idle_cnt_q != 4'hf)
        idle_cnt_q <= idle_cnt_q + 4'd1;
    end
  end

  // Old character kept on overrun
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      data_buffer_q <= 8'h00;
      bit8_q <= 1'b0;
    end else if (rx_new && !rx_full) begin
      data_buffer_q <= rx_char_in.data[7:0];
      bit8_q <= len9 ? rx_char_in.data[8] : rx_char_in.data[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over clear
  logic [7:0] st_set, st_clr;
  wire tx_empty_set = !en || tx_load_in || (wr_cr2 && wd[`USFFC_CR2_TE]
                      && !control_reg_two_q[`USFFC_CR2_TE]);
  assign st_set = {tx_empty_set,
                   !en || (status_reg_one_q[`USFFC_ST_TXE] && !tx_busy_in),
                   rx_new && !rx_full, idle_set, ovr,
                   rx_new && !rx_full && rx_char_in.noise,
                   rx_new && !rx_full && rx_char_in.framing,
                   rx_new && !rx_full && par_bad};
  assign st_clr = {clr_tx, en && tx_busy_in, clr_rx, clr_rx,
                   clr_rx, clr_rx, clr_rx, clr_rx};

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      status_reg_one_q <= `USFFC_ST_RESET;
      st1_seen_q <= 1'b0;
    end else begin
      status_reg_one_q <= st_set | (status_reg_one_q & ~st_clr);
      if (rd_st1 && may_clear)
        st1_seen_q <= 1'b1;
      else if ((clr_rx || clr_tx))
        st1_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests
  wire [3:0] err_en = control_reg_three_q[3:0];
  assign rx_irq_out = !standby && (
      (status_reg_one_q[`USFFC_ST_RXF] && control_reg_two_q[`USFFC_CR2_RXIE])
   || (status_reg_one_q[`USFFC_ST_IDLE]
       && control_reg_two_q[`USFFC_CR2_IDLE_IRQ_ENABLE]));
  assign err_irq_out = |(status_reg_one_q[3:0] & err_en);
  assign tx_irq_out = en && (
      (status_reg_one_q[`USFFC_ST_TXE] && control_reg_two_q[`USFFC_CR2_TXIE])
   || (status_reg_one_q[`USFFC_ST_TC]
       && control_reg_two_q[`USFFC_CR2_TCIE]));
  assign wake_request_out = rx_irq_out | err_irq_out | tx_irq_out;

  ////////////////////////////////////////////////////////////////////////
  sequence s_rx_new;
    rx_new && !rx_full;
  endsequence

  a_rxfull_set: assert property (@(posedge clock_in) disable iff (srst_in)
    s_rx_new |=> status_reg_one_q[`USFFC_ST_RXF])
    else $error("receive full not set");
  a_rx_irq_gate: assert property (@(posedge clock_in) disable iff (srst_in)
    rx_irq_out |-> control_reg_two_q[5] || control_reg_two_q[4])
    else $error("receive irq without enable");
  a_idle_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    idle_set |=> status_reg_one_q[`USFFC_ST_IDLE])
    else $error("idle flag not set");
  a_overrun_keep: assert property (@(posedge clock_in) disable iff (srst_in)
    ovr |=> $stable(data_buffer_q) && status_reg_one_q[3])
    else $error("overrun lost old data");
  a_err_irq_gate: assert property (@(posedge clock_in) disable iff (srst_in)
    err_irq_out |-> |(status_reg_one_q[3:0] & err_en))
    else $error("error irq without enabled flag");
  a_noise_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    s_rx_new ##0 rx_char_in.noise |=> status_reg_one_q[2])
    else $error("noise flag not set");
  a_frame_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    s_rx_new ##0 rx_char_in.framing |=> status_reg_one_q[1])
    else $error("framing flag not set");
  a_break_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    break_state_in && !break_clear_permit_in
    |=> ($past(status_reg_one_q) & ~status_reg_one_q) == 8'h00)
    else $error("flag cleared during protected break");
  a_tx_pin_out: assert property (@(posedge clock_in) disable iff (srst_in)
    en |-> serial_out_pin_oe_out && !serial_in_pin_oe_out)
    else $error("pin direction wrong while enabled");
  a_disable_tx: assert property (@(posedge clock_in) disable iff (srst_in)
    !en |=> status_reg_one_q[7:6] == 2'b11 && !tx_irq_out)
    else $error("disable did not set empty flags");
endmodule : usffc_top

// ### core/usffc_cfg.svh
// Register offsets, field positions and reset values of the serial flag block
`ifndef USFFC_CFG_SVH
`define USFFC_CFG_SVH
`define USFFC_OFF_LFC 8'h00
`define USFFC_OFF_CR2 8'h04
`define USFFC_OFF_CR3 8'h08
`define USFFC_OFF_ST1 8'h0c
`define USFFC_OFF_DATA 8'h10
`define USFFC_OFF_EVT 8'h14
`define USFFC_OFF_SYS 8'h18
// Line format control fields
`define USFFC_LFC_LOOP 7
`define USFFC_LFC_EN 6
`define USFFC_LFC_TX_POLARITY_INVERT 5
`define USFFC_LFC_LEN9 4
`define USFFC_LFC_WAKE 3
`define USFFC_LFC_IDLE_COUNT_START_SELECT 2
`define USFFC_LFC_PEN 1
`define USFFC_LFC_ODD 0
// Control two fields
`define USFFC_CR2_TXIE 7
`define USFFC_CR2_TCIE 6
`define USFFC_CR2_RXIE 5
`define USFFC_CR2_IDLE_IRQ_ENABLE 4
`define USFFC_CR2_TE 3
`define USFFC_CR2_RE 2
`define USFFC_CR2_STBY 1
// Status one fields
`define USFFC_ST_TXE 7
`define USFFC_ST_TC 6
`define USFFC_ST_RXF 5
`define USFFC_ST_IDLE 4
`define USFFC_ST_OR 3
`define USFFC_ST_NF 2
`define USFFC_ST_FE 1
`define USFFC_ST_PE 0
`define USFFC_ST_RESET 8'hc0
`define USFFC_IDLE_SHORT 4'd10
`define USFFC_IDLE_LONG 4'd11
`endif

// ### core/usffc_pkg.sv
// Types shared by the serial flag and format block
package usffc_pkg;
  typedef struct packed {
    logic valid;
    logic [8:0] data;
    logic noise;
    logic framing;
  } usffc_rxchar_type;
  typedef struct packed {
    logic tx_oe;
    logic tx_level;
    logic rx_ie;
  } usffc_pin_type;
  typedef enum logic [1:0] {
    USFFC_RD_IDLE = 2'b00,
    USFFC_RD_RESP = 2'b01
  } usffc_rd_state_type;
endpackage : usffc_pkg

// ### bench/usffc_remote.sv
// Remote serial device model driving the receive side of the block
module usffc_remote (
  // Clock
  input wire logic clock_in,
  // Receiver side
  output usffc_pkg::usffc_rxchar_type char_out,
  output logic idle_bit_out,
  // Line levels
  output logic tx_raw_out,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import usffc_pkg::*;
  initial begin
    char_out = '0;
    idle_bit_out = 1'b0;
    tx_raw_out = 1'b1;
    pin_out = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Stale fields are inverted so a held value is never mistaken for data
  task automatic send_char(input logic [8:0] d, input logic nz, fr);
    @(posedge clock_in);
    char_out <= {1'b1, d, nz, fr};
    @(posedge clock_in);
    char_out <= {1'b0, ~d, ~nz, ~fr};
  endtask : send_char
  task automatic idle_bits(input int n);
    repeat (n) begin
      @(posedge clock_in);
      idle_bit_out <= 1'b1;
      @(posedge clock_in);
      idle_bit_out <= 1'b0;
    end
  endtask : idle_bits
  task automatic lines(input logic tx, pin);
    @(posedge clock_in);
    tx_raw_out <= tx;
    pin_out <= pin;
  endtask : lines
endmodule : usffc_remote

// ### bench/usffc_bench.sv
// Self-checking bench for the serial flag and format block
`include "usffc_cfg.svh"
module usffc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import usffc_pkg::*;
  localparam logic [7:0] lf = `USFFC_OFF_LFC;
  localparam logic [7:0] c2 = `USFFC_OFF_CR2;
  localparam logic [7:0] c3 = `USFFC_OFF_CR3;
  localparam logic [7:0] st = `USFFC_OFF_ST1;
  localparam logic [7:0] dt = `USFFC_OFF_DATA;
  localparam logic [1:0] ok = 2'b00;
  logic clock_in, srst_in, s_axi_awvalid_in, s_axi_awready_out;
  logic s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, char_bits_out;
  usffc_rxchar_type rx_char_in;
  logic rx_idle_bit_in, tx_serial_in, tx_load_in, tx_busy_in;
  logic rx_serial_out, odd_parity_out, parity_enable_out;
  logic baud_enable_out, wait_mode_in, stop_mode_in, break_state_in;
  logic break_clear_permit_in, tx_pin_direction_in, rx_pin_direction_in;
  logic serial_in_pin_in, serial_out_pin_out, serial_out_pin_oe_out;
  logic serial_in_pin_oe_out, rx_irq_out, err_irq_out, tx_irq_out;
  logic wake_request_out;
  int error_cnt, compares, i, k;
  logic [7:0] d, v;
  logic [33:0] expq[$];

  usffc_top dut (.*);
  usffc_remote remote (
    .clock_in(clock_in),
    .char_out(rx_char_in),
    .idle_bit_out(rx_idle_bit_in),
    .tx_raw_out(tx_serial_in),
    .pin_out(serial_in_pin_in)
  );

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s %h not %h", $time, msg, seen, exp);
    end
  endtask : check
  // Responses are matched in issue order
  always @(posedge clock_in) begin
    if (s_axi_bvalid_out === 1'b1 && s_axi_bready_in)
      check({s_axi_bresp_out, 32'h0}, expq.pop_front(), "wr");
    if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in)
      check({s_axi_rresp_out, s_axi_rdata_out}, expq.pop_front(), "rd");
  end
  task automatic wr(input logic [7:0] a, dv, input logic [1:0] r);
    int n;
    expq.push_back({r, 32'h0});
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, dv};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1 && n < 40);
    s_axi_bready_in <= 1'b0;
    @(posedge clock_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, dv, input logic [1:0] r);
    int n;
    expq.push_back({r, 24'h0, dv});
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1 && n < 40);
    s_axi_rready_in <= 1'b0;
    @(posedge clock_in);
  endtask : rd
  task automatic tally_and_finish();
    check(34'(expq.size()), 34'h0, "left over");
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Run needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in,
     s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in,
     tx_load_in, tx_busy_in, wait_mode_in, stop_mode_in, break_state_in,
     break_clear_permit_in, tx_pin_direction_in, rx_pin_direction_in} = '0;
    s_axi_wstrb_in = 4'hf;
    srst_in = 1'b1;
    error_cnt = 0;
    compares = 0;
    void'($urandom(77792));
    repeat (20) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    rd(st, 8'hc0, ok);
    rd(lf, 8'h00, ok);
    rd(8'h1c, 8'h00, 2'b10);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      v = 8'h40 | 8'($urandom() & 32'h3f);
      tx_pin_direction_in <= 1'($urandom());
      rx_pin_direction_in <= 1'($urandom());
      remote.lines(i[0], 1'b1);
      wr(lf, v, ok);
      rd(lf, v, ok);
      check(34'({char_bits_out, odd_parity_out, parity_enable_out,
        baud_enable_out}), 34'({1'b0, v[4], v[0], v[1], 1'b1}), "fmt");
      check(34'({serial_out_pin_oe_out, serial_in_pin_oe_out}), 34'h2,
        "pin dir");
      check(34'(serial_out_pin_out), 34'(i[0] ^ v[5]), "tx level");
    end
    $display("format test done");
    wr(lf, 8'hc0, ok);
    wr(c2, 8'h0c, ok);
    for (i = 0; i < 4; i++) begin
      remote.lines(i[0], ~i[0]);
      repeat (3) @(posedge clock_in);
      check(34'(rx_serial_out), 34'(i[0] ^ (i > 1)), "rx in");
      if (i == 1) wr(lf, 8'h40, ok);
    end
    $display("loopback test done");
    d = 8'($urandom());
    v = 8'($urandom());
    remote.send_char({1'b0, d}, 1'b0, 1'b0);
    repeat (2) @(posedge clock_in);
    check(34'(rx_irq_out), 34'h0, "rx masked");
    wr(c2, 8'h2c, ok);
    check(34'(rx_irq_out), 34'h1, "rx irq");
    remote.send_char({1'b0, v}, 1'b0, 1'b0);
    rd(st, 8'he8, ok);
    check(34'(err_irq_out), 34'h0, "or masked");
    wr(c3, 8'h08, ok);
    check(34'(err_irq_out), 34'h1, "or irq");
    wr(c3, 8'h00, ok);
    rd(dt, d, ok);
    rd(st, 8'hc0, ok);
    $display("overrun test done");
    // Noise, framing and parity in turn, parity sense random
    for (k = 0; k < 3; k++) begin
      v = 8'($urandom() & 32'h1);
      wr(lf, 8'h42 | v, ok);
      d = 8'($urandom() & 32'h7f);
      d[7] = ^d[6:0] ^ v[0] ^ (k == 2);
      remote.send_char({1'b0, d}, k == 0, k == 1);
      rd(st, 8'he0 | (8'h04 >> k), ok);
      check(34'(err_irq_out), 34'h0, "err masked");
      wr(c3, 8'h04 >> k, ok);
      check(34'(err_irq_out), 34'h1, "err irq");
      wr(c3, 8'h00, ok);
      rd(dt, d, ok);
      rd(st, 8'hc0, ok);
    end
    $display("error flag test done");
    wr(c2, 8'h0c, ok);
    for (i = 0; i < 2; i++) begin
      wr(lf, 8'h40 | 8'(i << 4), ok);
      d = 8'($urandom() & 32'h7f);
      remote.send_char({1'($urandom()), d}, 1'b0, 1'b0);
      remote.idle_bits(9 + i);
      rd(st, 8'he0, ok);
      remote.idle_bits(1);
      rd(st, 8'hf0, ok);
      check(34'(rx_irq_out), 34'h0, "idle masked");
      wr(c2, 8'h1c, ok);
      check(34'(rx_irq_out), 34'h1, "idle irq");
      wr(c2, 8'h0c, ok);
      rd(dt, d, ok);
      rd(st, 8'hc0, ok);
    end
    $display("idle test done");
    wr(lf, 8'h48, ok);
    wr(c2, 8'h0e, ok);
    d = 8'h80 | 8'($urandom());
    remote.send_char({1'b0, d}, 1'b0, 1'b0);
    rd(c2, 8'h0c, ok);
    rd(st, 8'he0, ok);
    rd(dt, d, ok);
    wr(c2, 8'h2c, ok);
    wait_mode_in <= 1'b1;
    rd(st, 8'h00, 2'b10);
    check(34'(wake_request_out), 34'h0, "no wake");
    remote.send_char({1'b0, d}, 1'b0, 1'b0);
    repeat (2) @(posedge clock_in);
    check(34'(wake_request_out), 34'h1, "wake");
    wait_mode_in <= 1'b0;
    rd(st, 8'he0, ok);
    break_state_in <= 1'b1;
    rd(dt, d, ok);
    check(34'(rx_irq_out), 34'h1, "flag held");
    break_state_in <= 1'b0;
    rd(dt, d, ok);
    check(34'(rx_irq_out), 34'h0, "flag cleared");
    remote.send_char({1'b0, d}, 1'b0, 1'b0);
    break_clear_permit_in <= 1'b1;
    break_state_in <= 1'b1;
    rd(st, 8'he0, ok);
    rd(dt, d, ok);
    break_state_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check(34'(rx_irq_out), 34'h0, "stays clear");
    $display("mode test done");
    stop_mode_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    stop_mode_in <= 1'b0;
    rd(lf, 8'h48, ok);
    wr(c2, 8'hac, ok);
    check(34'(tx_irq_out), 34'h1, "tx irq");
    rd(st, 8'hc0, ok);
    wr(dt, 8'h55, ok);
    check(34'(tx_irq_out), 34'h0, "tx empty clr");
    wr(lf, 8'h08, ok);
    rd(st, 8'hc0, ok);
    check(34'({tx_irq_out, baud_enable_out}), 34'h0, "disabled");
    $display("enable test done");
    tally_and_finish();
  end
endmodule : usffc_bench
